// ---- rtl/ofd_decoder.sv ----
// operand field decoder top: field extraction, shadow, flags and register port
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "ofd_map.svh"

// Contract
// - access bit clear: address the fixed access region, ignore bank register
// - access bit set: data address bank comes from the bank register
// - three-bit bit field picks one bit 0 to 7 of a byte
// - destination bit 0 goes to accumulator, 1 back to the file register
// - short file field is an 8-bit address or 2-bit pointer selector
// - register moves carry 12-bit source and 12-bit target addresses
// - literals are 8, 12 or 20 bits wide per format
// - branch field is signed relative offset or absolute call/jump target
// - table action: keep, post-increment, post-decrement or pre-increment
// - table pointer is 21 bits and addresses program memory
// - fast bit saves or restores shadow registers; clear leaves them alone
// - 7-bit source and target offsets for indexed indirect access
// - don't-care bits of a word are ignored
// - results report carry, half carry, zero, overflow and negative
// - tail words start with ones; a lone tail runs as no-operation
module ofd_decoder
	import ofd_pkg::*;
#(
	parameter int PTR_WIDTH = 21,
	parameter int DATA_W    = 32
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 instr_valid,
	input  wire logic [15:0]          instr_word,
	input  wire ofd_fmt_t             instr_format,
	input  wire logic [7:0]           working_accumulator_in,
	input  wire logic [4:0]           status_in,
	input  wire logic                 alu_valid,
	input  wire logic [7:0]           alu_a,
	input  wire logic [7:0]           alu_b,
	input  wire logic                 alu_carry_in,
	input  wire logic                 alu_subtract,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [DATA_W-1:0]    reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output logic      [DATA_W-1:0]    reg_rdata,
	output logic                      dec_valid_reg,
	output ofd_fmt_t                  dec_format_reg,
	output logic                      dec_nop_reg,
	output logic                      dec_ram_access_reg,
	output logic                      dec_dest_file_reg,
	output logic      [2:0]           dec_bit_pos_reg,
	output logic      [7:0]           dec_bit_mask_reg,
	output logic      [11:0]          dec_data_addr_reg,
	output logic      [1:0]           dec_pointer_sel_reg,
	output logic      [11:0]          move_source_address_reg,
	output logic      [11:0]          move_target_address_reg,
	output logic      [6:0]           indexed_source_offset_reg,
	output logic      [6:0]           indexed_target_offset_reg,
	output logic      [19:0]          dec_literal_reg,
	output logic                      branch_relative_reg,
	output logic      [19:0]          branch_value_reg,
	output logic                      fast_mode_reg,
	output logic                      shadow_restore_reg,
	output logic      [7:0]           restore_accumulator_reg,
	output logic      [4:0]           restore_status_reg,
	output logic      [PTR_WIDTH-1:0] table_pointer,
	output logic      [PTR_WIDTH-1:0] table_access_addr,
	output logic                      table_access_valid,
	output logic                      carry_flag_reg,
	output logic                      half_carry_flag_reg,
	output logic                      zero_flag_reg,
	output logic                      signed_range_flag_reg,
	output logic                      negative_flag_reg
);

	// the register port must hold the whole table pointer in one word
	if (DATA_W < PTR_WIDTH || DATA_W < 21) begin : g_width_check
		$error("ofd_decoder: DATA_W too narrow for the table pointer");
	end

	ofd_state_t  state_reg;
	logic [15:0] pend_word_reg;
	ofd_fmt_t    pend_fmt_reg;
	logic [3:0]  bank_select_reg;
	logic [7:0]  shadow_accumulator_reg;
	logic [4:0]  shadow_status_reg;
	logic [3:0]  shadow_bank_reg;
	logic        in_second;
	logic        word_is_tail;
	logic        start_pair;
	logic        take;
	logic        nop_cur;
	ofd_fmt_t    fmt_cur;
	logic [15:0] w1;
	logic [15:0] w2;
	logic        tbl_op;
	logic        save_shadow;
	logic        restore_shadow;
	logic [7:0]  alu_b_eff;
	logic [8:0]  alu_sum;
	logic [4:0]  alu_half;

	// formats that occupy two program words
	function automatic logic is_double(input ofd_fmt_t f);
		return (f == OFD_FMT_LFSR) || (f == OFD_FMT_MOVFF) || (f == OFD_FMT_CALL) ||
		       (f == OFD_FMT_GOTO) || (f == OFD_FMT_MOVSF) || (f == OFD_FMT_MOVSS);
	endfunction

	// 12-bit data address from the access bit, short file field and bank
	function automatic logic [11:0] data_address(input logic a, input logic [7:0] f, input logic [3:0] bank);
		if (a) begin
			return {bank, f};
		end
		// fixed region split on the top bit of the field, bank register unused
		return {(f[7] ? `OFD_ACCESS_HI_BANK : `OFD_ACCESS_LO_BANK), f};
	endfunction

	// sign extension of a relative branch offset to the address width
	function automatic logic [19:0] sext(input logic [10:0] v);
		return {{9{v[10]}}, v};
	endfunction

	// pairing of first and tail words
	assign in_second    = (state_reg == OFD_ST_SECOND);
	assign word_is_tail = (instr_word[15:12] == `OFD_TAIL_PREFIX);
	assign fmt_cur      = in_second ? pend_fmt_reg : instr_format;
	assign w1           = in_second ? pend_word_reg : instr_word;
	assign w2           = instr_word;
	assign nop_cur      = in_second ? !word_is_tail : word_is_tail;
	assign start_pair   = instr_valid && !in_second && !word_is_tail && is_double(instr_format);
	assign take         = instr_valid && !start_pair;

	// side effects of a taken instruction
	assign tbl_op         = take && !nop_cur && (fmt_cur == OFD_FMT_TABLE);
	assign save_shadow    = take && !nop_cur && (fmt_cur == OFD_FMT_CALL) && w1[`OFD_S_CALL_BIT];
	assign restore_shadow = take && !nop_cur && (fmt_cur == OFD_FMT_RET) && w1[`OFD_S_RET_BIT];

	// first word held while the tail word is awaited
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg     <= OFD_ST_IDLE;
			pend_word_reg <= 16'h0000;
			pend_fmt_reg  <= OFD_FMT_NONE;
		end else if (instr_valid) begin
			case (state_reg)
				OFD_ST_IDLE: begin
					if (start_pair) begin
						state_reg     <= OFD_ST_SECOND;
						pend_word_reg <= instr_word;
						pend_fmt_reg  <= instr_format;
					end
				end
				OFD_ST_SECOND: state_reg <= OFD_ST_IDLE;
				default:       state_reg <= OFD_ST_IDLE;
			endcase
		end
	end

	// field extraction; every field of a word is registered on the same edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dec_valid_reg             <= 1'b0;
			dec_format_reg            <= OFD_FMT_NONE;
			dec_nop_reg               <= 1'b0;
			dec_ram_access_reg        <= 1'b0;
			dec_dest_file_reg         <= 1'b0;
			dec_bit_pos_reg           <= 3'h0;
			dec_bit_mask_reg          <= 8'h00;
			dec_data_addr_reg         <= 12'h000;
			dec_pointer_sel_reg       <= 2'h0;
			move_source_address_reg   <= 12'h000;
			move_target_address_reg   <= 12'h000;
			indexed_source_offset_reg <= 7'h00;
			indexed_target_offset_reg <= 7'h00;
			dec_literal_reg           <= 20'h00000;
			branch_relative_reg       <= 1'b0;
			branch_value_reg          <= 20'h00000;
			fast_mode_reg             <= 1'b0;
		end else begin
			dec_valid_reg <= take;
			if (take) begin
				// fields unused by the format, and don't-care bits, read as zero
				dec_format_reg            <= nop_cur ? OFD_FMT_NONE : fmt_cur;
				dec_nop_reg               <= nop_cur;
				dec_ram_access_reg        <= 1'b0;
				dec_dest_file_reg         <= 1'b0;
				dec_bit_pos_reg           <= 3'h0;
				dec_bit_mask_reg          <= 8'h00;
				dec_data_addr_reg         <= 12'h000;
				dec_pointer_sel_reg       <= 2'h0;
				move_source_address_reg   <= 12'h000;
				move_target_address_reg   <= 12'h000;
				indexed_source_offset_reg <= 7'h00;
				indexed_target_offset_reg <= 7'h00;
				dec_literal_reg           <= 20'h00000;
				branch_relative_reg       <= 1'b0;
				branch_value_reg          <= 20'h00000;
				fast_mode_reg             <= 1'b0;
				if (!nop_cur) begin
					case (fmt_cur)
						OFD_FMT_BYTE: begin
							dec_ram_access_reg <= w1[`OFD_A_BIT];
							dec_dest_file_reg  <= w1[`OFD_D_BIT];
							dec_data_addr_reg  <= data_address(w1[`OFD_A_BIT], w1[7:0], bank_select_reg);
						end
						OFD_FMT_BIT: begin
							dec_ram_access_reg <= w1[`OFD_A_BIT];
							dec_bit_pos_reg    <= w1[11:9];
							dec_bit_mask_reg   <= 8'h01 << w1[11:9];
							dec_data_addr_reg  <= data_address(w1[`OFD_A_BIT], w1[7:0], bank_select_reg);
						end
						OFD_FMT_LIT8:  dec_literal_reg <= {12'h000, w1[7:0]};
						OFD_FMT_LFSR: begin
							dec_pointer_sel_reg <= w1[5:4];
							dec_literal_reg     <= {8'h00, w1[3:0], w2[7:0]};
						end
						OFD_FMT_MOVFF: begin
							move_source_address_reg <= w1[11:0];
							move_target_address_reg <= w2[11:0];
						end
						OFD_FMT_CALL: begin
							fast_mode_reg    <= w1[`OFD_S_CALL_BIT];
							dec_literal_reg  <= {w2[11:0], w1[7:0]};
							branch_value_reg <= {w2[11:0], w1[7:0]};
						end
						OFD_FMT_GOTO: begin
							dec_literal_reg  <= {w2[11:0], w1[7:0]};
							branch_value_reg <= {w2[11:0], w1[7:0]};
						end
						OFD_FMT_BRA: begin
							branch_relative_reg <= 1'b1;
							branch_value_reg    <= sext(w1[10:0]);
						end
						OFD_FMT_BCOND: begin
							branch_relative_reg <= 1'b1;
							branch_value_reg    <= sext({{3{w1[7]}}, w1[7:0]});
						end
						OFD_FMT_RET:   fast_mode_reg <= w1[`OFD_S_RET_BIT];
						OFD_FMT_MOVSF: begin
							indexed_source_offset_reg <= w1[6:0];
							move_target_address_reg   <= w2[11:0];
						end
						OFD_FMT_MOVSS: begin
							indexed_source_offset_reg <= w1[6:0];
							indexed_target_offset_reg <= w2[6:0];
						end
						default: dec_literal_reg <= 20'h00000;
					endcase
				end
			end
		end
	end

	// shadow copies taken on a fast call, untouched otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shadow_accumulator_reg <= 8'h00;
			shadow_status_reg      <= 5'h00;
			shadow_bank_reg        <= `OFD_BANK_RST;
		end else if (save_shadow) begin
			shadow_accumulator_reg <= working_accumulator_in;
			shadow_status_reg      <= status_in;
			shadow_bank_reg        <= bank_select_reg;
		end
	end

	// values handed back on a fast return
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shadow_restore_reg      <= 1'b0;
			restore_accumulator_reg <= 8'h00;
			restore_status_reg      <= 5'h00;
		end else begin
			shadow_restore_reg <= restore_shadow;
			if (restore_shadow) begin
				restore_accumulator_reg <= shadow_accumulator_reg;
				restore_status_reg      <= shadow_status_reg;
			end
		end
	end

	// bank register: a fast return overrides a software write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_select_reg <= `OFD_BANK_RST;
		end else if (restore_shadow) begin
			bank_select_reg <= shadow_bank_reg;
		end else if (reg_write && reg_addr == `OFD_BANK_OFS) begin
			bank_select_reg <= reg_wdata[3:0];
		end
	end

	// table pointer and its access address
	ofd_table_pointer #(
		.PTR_WIDTH(PTR_WIDTH)
	) u_table_pointer (
		.clk             (clk),
		.rst             (rst),
		.op_valid        (tbl_op),
		.action          (ofd_tbl_act_t'(w1[1:0])),
		.sw_load         (reg_write && reg_addr == `OFD_TABLE_POINTER_OFS),
		.sw_value        (reg_wdata[PTR_WIDTH-1:0]),
		.ptr_reg         (table_pointer),
		.access_addr_reg (table_access_addr),
		.access_valid_reg(table_access_valid)
	);

	// adder for the status flags; subtraction adds the complement
	assign alu_b_eff = alu_subtract ? ~alu_b : alu_b;
	assign alu_sum   = {1'b0, alu_a} + {1'b0, alu_b_eff} + {8'h00, alu_carry_in};
	assign alu_half  = {1'b0, alu_a[3:0]} + {1'b0, alu_b_eff[3:0]} + {4'h0, alu_carry_in};

	// five status flags registered per arithmetic result
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carry_flag_reg        <= 1'b0;
			half_carry_flag_reg   <= 1'b0;
			zero_flag_reg         <= 1'b0;
			signed_range_flag_reg <= 1'b0;
			negative_flag_reg     <= 1'b0;
		end else if (alu_valid) begin
			carry_flag_reg        <= alu_sum[8];
			half_carry_flag_reg   <= alu_half[4];
			zero_flag_reg         <= (alu_sum[7:0] == 8'h00);
			signed_range_flag_reg <= (alu_a[7] == alu_b_eff[7]) && (alu_sum[7] != alu_a[7]);
			negative_flag_reg     <= alu_sum[7];
		end
	end

	// read data stand for exactly one cycle after the read strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `OFD_RDATA_RST;
		end else if (reg_read) begin
			case (reg_addr)
				`OFD_BANK_OFS:   reg_rdata <= DATA_W'({bank_select_reg});
				`OFD_TABLE_POINTER_OFS: reg_rdata <= DATA_W'(table_pointer);
				`OFD_SHADOW_OFS: reg_rdata <= DATA_W'({shadow_bank_reg, shadow_status_reg, shadow_accumulator_reg});
				`OFD_STATE_OFS:  reg_rdata <= DATA_W'({state_reg, carry_flag_reg, half_carry_flag_reg,
				                                       zero_flag_reg, signed_range_flag_reg, negative_flag_reg});
				default:         reg_rdata <= `OFD_RDATA_RST;
			endcase
		end else begin
			reg_rdata <= `OFD_RDATA_RST;
		end
	end

	// checks on the decoder outputs
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_access_fixed;
		take && !nop_cur && fmt_cur == OFD_FMT_BYTE && !w1[`OFD_A_BIT] |=>
			dec_data_addr_reg == {($past(w1[7]) ? 4'hF : 4'h0), $past(w1[7:0])};
	endproperty
	a_access_fixed: assert property (p_access_fixed) else $error("fixed region address wrong");

	property p_bank_used;
		take && !nop_cur && fmt_cur == OFD_FMT_BIT && w1[`OFD_A_BIT] |=>
			dec_data_addr_reg[11:8] == $past(bank_select_reg);
	endproperty
	a_bank_used: assert property (p_bank_used) else $error("bank not taken from bank register");

	property p_bit_mask;
		dec_valid_reg && dec_format_reg == OFD_FMT_BIT |-> dec_bit_mask_reg == (8'h01 << dec_bit_pos_reg);
	endproperty
	a_bit_mask: assert property (p_bit_mask) else $error("bit mask does not match position");

	property p_dest;
		take && !nop_cur && fmt_cur == OFD_FMT_BYTE |=> dec_dest_file_reg == $past(w1[`OFD_D_BIT]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination bit lost");

	property p_pair;
		start_pair ##1 (instr_valid && word_is_tail && pend_fmt_reg == OFD_FMT_MOVFF) |=>
			dec_valid_reg && move_source_address_reg == $past(pend_word_reg[11:0]) &&
			move_target_address_reg == $past(instr_word[11:0]);
	endproperty
	a_pair: assert property (p_pair) else $error("move addresses not paired");

	property p_relative;
		take && !nop_cur && fmt_cur == OFD_FMT_BRA |=>
			branch_relative_reg && branch_value_reg[19:10] == {10{branch_value_reg[10]}};
	endproperty
	a_relative: assert property (p_relative) else $error("relative offset not sign extended");

	property p_pre_inc;
		tbl_op && w1[1:0] == 2'b11 |=> table_access_addr == table_pointer && table_access_valid;
	endproperty
	a_pre_inc: assert property (p_pre_inc) else $error("pre-increment access address wrong");

	property p_shadow_hold;
		!save_shadow |=> $stable(shadow_accumulator_reg) && $stable(shadow_status_reg);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed without fast call");

	property p_lone_tail;
		instr_valid && !in_second && word_is_tail |=> dec_valid_reg && dec_nop_reg && !branch_relative_reg;
	endproperty
	a_lone_tail: assert property (p_lone_tail) else $error("lone tail word not a no-operation");

	property p_wait_tail;
		start_pair |=> !dec_valid_reg && in_second;
	endproperty
	a_wait_tail: assert property (p_wait_tail) else $error("first word of pair decoded alone");

	property p_zero;
		alu_valid |=> zero_flag_reg == ($past(alu_sum[7:0]) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	c_fast_call: cover property (save_shadow);
	c_fast_ret:  cover property (restore_shadow);
	c_pre_inc:   cover property (tbl_op && w1[1:0] == 2'b11);
	c_lone_tail: cover property (instr_valid && !in_second && word_is_tail);

endmodule

// ---- rtl/ofd_map.svh ----
// offsets, field positions and reset values of the operand field decoder
`ifndef OFD_MAP_SVH
`define OFD_MAP_SVH

// register word offsets on the plain register port
`define OFD_BANK_OFS        8'h00
`define OFD_TABLE_POINTER_OFS      8'h04
`define OFD_SHADOW_OFS      8'h08
`define OFD_STATE_OFS       8'h0C

// reset values
`define OFD_BANK_RST        4'h0
`define OFD_RDATA_RST       32'h0000_0000

// tail word of a double-word instruction carries this prefix
`define OFD_TAIL_PREFIX     4'hF

// fixed access region: low half from bank 0, high half from the top bank
`define OFD_ACCESS_LO_BANK  4'h0
`define OFD_ACCESS_HI_BANK  4'hF

// single-bit field positions in the first word
`define OFD_D_BIT           9
`define OFD_A_BIT           8
`define OFD_S_CALL_BIT      8
`define OFD_S_RET_BIT       0

`endif

// ---- rtl/ofd_pkg.sv ----
// types shared by the operand field decoder
package ofd_pkg;

	typedef enum logic [3:0] {
		OFD_FMT_NONE  = 4'h0,
		OFD_FMT_BYTE  = 4'h1,
		OFD_FMT_BIT   = 4'h2,
		OFD_FMT_LIT8  = 4'h3,
		OFD_FMT_LFSR  = 4'h4,
		OFD_FMT_MOVFF = 4'h5,
		OFD_FMT_CALL  = 4'h6,
		OFD_FMT_GOTO  = 4'h7,
		OFD_FMT_BRA   = 4'h8,
		OFD_FMT_BCOND = 4'h9,
		OFD_FMT_RET   = 4'hA,
		OFD_FMT_TABLE = 4'hB,
		OFD_FMT_MOVSF = 4'hC,
		OFD_FMT_MOVSS = 4'hD
	} ofd_fmt_t;

	typedef enum logic [1:0] {
		OFD_TBL_KEEP     = 2'b00,
		OFD_TBL_POST_INC = 2'b01,
		OFD_TBL_POST_DEC = 2'b10,
		OFD_TBL_PRE_INC  = 2'b11
	} ofd_tbl_act_t;

	typedef enum logic {
		OFD_ST_IDLE   = 1'b0,
		OFD_ST_SECOND = 1'b1
	} ofd_state_t;

endpackage

// ---- rtl/ofd_table_pointer.sv ----
// table pointer with its four access actions
`timescale 1ns/100ps
`include "ofd_map.svh"

module ofd_table_pointer
	import ofd_pkg::*;
#(
	parameter int PTR_WIDTH = 21
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 op_valid,
	input  wire ofd_tbl_act_t         action,
	input  wire logic                 sw_load,
	input  wire logic [PTR_WIDTH-1:0] sw_value,
	output logic      [PTR_WIDTH-1:0] ptr_reg,
	output logic      [PTR_WIDTH-1:0] access_addr_reg,
	output logic                      access_valid_reg
);

	// the increment and decrement need at least two bits to be meaningful
	if (PTR_WIDTH < 2) begin : g_width_check
		$error("ofd_table_pointer: PTR_WIDTH below 2");
	end

	// pointer update; a table access wins over a software load in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_reg <= '0;
		end else if (op_valid) begin
			case (action)
				OFD_TBL_KEEP:     ptr_reg <= ptr_reg;
				OFD_TBL_POST_INC: ptr_reg <= ptr_reg + 1'b1;
				OFD_TBL_POST_DEC: ptr_reg <= ptr_reg - 1'b1;
				OFD_TBL_PRE_INC:  ptr_reg <= ptr_reg + 1'b1;
				default:          ptr_reg <= ptr_reg;
			endcase
		end else if (sw_load) begin
			ptr_reg <= sw_value;
		end
	end

	// program memory address used by the access itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			access_addr_reg  <= '0;
			access_valid_reg <= 1'b0;
		end else begin
			access_valid_reg <= op_valid;
			if (op_valid) begin
				// pre-increment accesses the new value, the others the old one
				access_addr_reg <= (action == OFD_TBL_PRE_INC) ? ptr_reg + 1'b1 : ptr_reg;
			end
		end
	end

endmodule

// ---- sim/ofd_fetch_model.sv ----
// fetch stage stand-in that presents program words to the decoder
`timescale 1ns/100ps

module ofd_fetch_model
	import ofd_pkg::*;
(
	input  wire logic        clk,
	output logic             instr_valid,
	output logic [15:0]      instr_word,
	output ofd_fmt_t         instr_format
);
	// idle at time zero with a busy pattern on the word lines
	initial begin
		instr_valid = 1'b0;
		instr_word = 16'hA5A5;
		instr_format = OFD_FMT_NONE;
	end

	// present one word for one cycle; calls may follow back to back
	task put(input logic [15:0] w, input ofd_fmt_t f);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		instr_format <= f;
	endtask

	// end a burst; released lines show the inverse so a stale word never decodes by luck
	task fin;
		@(posedge clk);
		instr_valid <= 1'b0;
		instr_word <= ~instr_word;
		instr_format <= ofd_fmt_t'(~instr_format);
		#1;
	endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking testbench for the operand field decoder
`timescale 1ns/100ps
`include "ofd_map.svh"

module testbench
	import ofd_pkg::*;
;
	logic        clk, rst, alu_valid, alu_carry_in, alu_subtract, reg_write, reg_read, instr_valid;
	logic        dec_valid_reg, dec_nop_reg, dec_ram_access_reg, dec_dest_file_reg, branch_relative_reg;
	logic        fast_mode_reg, shadow_restore_reg, table_access_valid, carry_flag_reg, half_carry_flag_reg;
	logic        zero_flag_reg, signed_range_flag_reg, negative_flag_reg;
	logic [7:0]  working_accumulator_in, alu_a, alu_b, reg_addr, dec_bit_mask_reg, restore_accumulator_reg;
	logic [4:0]  status_in, restore_status_reg;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] instr_word;
	logic [2:0]  dec_bit_pos_reg;
	logic [1:0]  dec_pointer_sel_reg;
	logic [11:0] dec_data_addr_reg, move_source_address_reg, move_target_address_reg;
	logic [6:0]  indexed_source_offset_reg, indexed_target_offset_reg;
	logic [19:0] dec_literal_reg, branch_value_reg;
	logic [20:0] table_pointer, table_access_addr, p, e;
	ofd_fmt_t    instr_format, dec_format_reg;
	int          n_mismatch, checks_done;

	ofd_decoder #(.PTR_WIDTH(21), .DATA_W(32)) uut (.*);
	ofd_fetch_model fetch (.*);

	// free-running 50 MHz clock
	always #10 clk = ~clk;

	// compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// register port accesses, one cycle strobes
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge clk);
		reg_read <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(nm, reg_rdata, exp);
	endtask

	// single word, then word pair; the answer pulse is looked at in its own cycle
	task one(input logic [15:0] w, input ofd_fmt_t f);
		fetch.put(w, f);
		fetch.fin;
		chk("valid", dec_valid_reg, 1'b1);
	endtask

	task two(input logic [15:0] w1, input logic [15:0] w2, input ofd_fmt_t f);
		fetch.put(w1, f);
		fetch.put(w2, f);
		fetch.fin;
		chk("valid", dec_valid_reg, 1'b1);
	endtask

	task alu(input logic [7:0] a, input logic [7:0] b, input logic s, input logic c, input logic [4:0] exp);
		@(posedge clk);
		alu_valid <= 1'b1; alu_a <= a; alu_b <= b; alu_subtract <= s; alu_carry_in <= c;
		@(posedge clk);
		alu_valid <= 1'b0;
		#1 chk("flags", {carry_flag_reg, half_carry_flag_reg, zero_flag_reg, signed_range_flag_reg,
			negative_flag_reg}, exp);
	endtask

	// main sequence
	initial begin
		clk = 0; rst = 1; alu_valid = 0; alu_a = 0; alu_b = 0; alu_carry_in = 0; alu_subtract = 0;
		reg_write = 0; reg_read = 0; reg_addr = 0; reg_wdata = 0; working_accumulator_in = 8'h5A; status_in = 5'h13;
		n_mismatch = 0; checks_done = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(`OFD_BANK_OFS, 32'h0, "bank");
		rd(`OFD_TABLE_POINTER_OFS, 32'h0, "pointer");
		rd(8'h10, 32'h0, "unmapped");
		$display("test reset finished");
		one(16'h2685, OFD_FMT_BYTE);
		chk("addr", dec_data_addr_reg, 12'hF85);
		chk("access", dec_ram_access_reg, 1'b0);
		chk("dest", dec_dest_file_reg, 1'b1);
		wr(`OFD_BANK_OFS, 32'h3);
		one(16'h2405, OFD_FMT_BYTE);
		chk("addr", dec_data_addr_reg, 12'h005);
		one(16'h2505, OFD_FMT_BYTE);
		chk("addr", dec_data_addr_reg, 12'h305);
		chk("dest", dec_dest_file_reg, 1'b0);
		for (int b = 0; b < 8; b++) begin
			one({4'h8, b[2:0], 1'b1, 8'h10}, OFD_FMT_BIT);
			chk("bitpos", dec_bit_pos_reg, b[2:0]);
			chk("mask", dec_bit_mask_reg, 8'h01 << b);
			chk("addr", dec_data_addr_reg, 12'h310);
		end
		$display("test byte and bit finished");
		one(16'h0E7F, OFD_FMT_LIT8);
		chk("lit8", dec_literal_reg, 20'h0007F);
		two(16'hEE2A, 16'hF0BC, OFD_FMT_LFSR);
		chk("ptrsel", dec_pointer_sel_reg, 2'h2);
		chk("lit12", dec_literal_reg, 20'h00ABC);
		two(16'hC123, 16'hF456, OFD_FMT_MOVFF);
		chk("src", move_source_address_reg, 12'h123);
		chk("tgt", move_target_address_reg, 12'h456);
		two(16'hEBF5, 16'hF03A, OFD_FMT_MOVSS);
		chk("isrc", indexed_source_offset_reg, 7'h75);
		chk("itgt", indexed_target_offset_reg, 7'h3A);
		two(16'hEB85, 16'hF7AB, OFD_FMT_MOVSF);
		chk("isrc", indexed_source_offset_reg, 7'h05);
		chk("tgt", move_target_address_reg, 12'h7AB);
		two(16'hEF12, 16'hF345, OFD_FMT_GOTO);
		chk("goto", branch_value_reg, 20'h34512);
		chk("lit20", dec_literal_reg, 20'h34512);
		chk("fmt", dec_format_reg, OFD_FMT_GOTO);
		chk("nop", dec_nop_reg, 1'b0);
		one(16'hD7FE, OFD_FMT_BRA);
		chk("bra", branch_value_reg, 20'hFFFFE);
		chk("rel", branch_relative_reg, 1'b1);
		one(16'hE280, OFD_FMT_BCOND);
		chk("bcond", branch_value_reg, 20'hFFF80);
		$display("test literals and branches finished");
		two(16'hED34, 16'hF567, OFD_FMT_CALL);
		chk("lit20", dec_literal_reg, 20'h56734);
		chk("target", branch_value_reg, 20'h56734);
		chk("rel", branch_relative_reg, 1'b0);
		chk("fast", fast_mode_reg, 1'b1);
		rd(`OFD_SHADOW_OFS, 32'h735A, "shadow");
		working_accumulator_in <= 8'h11;
		two(16'hEC34, 16'hF567, OFD_FMT_CALL);
		rd(`OFD_SHADOW_OFS, 32'h735A, "shadow");
		wr(`OFD_BANK_OFS, 32'h5);
		one(16'h0013, OFD_FMT_RET);
		chk("restore", shadow_restore_reg, 1'b1);
		chk("fast", fast_mode_reg, 1'b1);
		chk("racc", restore_accumulator_reg, 8'h5A);
		chk("rstat", restore_status_reg, 5'h13);
		rd(`OFD_BANK_OFS, 32'h3, "bank");
		one(16'h0012, OFD_FMT_RET);
		chk("restore", shadow_restore_reg, 1'b0);
		$display("test fast call finished");
		wr(`OFD_TABLE_POINTER_OFS, 32'h1FFFFF);
		p = 21'h1FFFFF;
		for (int m = 0; m < 4; m++) begin
			e = (m == 3) ? p + 21'h1 : p;
			p = (m == 1 || m == 3) ? p + 21'h1 : (m == 2) ? p - 21'h1 : p;
			one({14'h0002, m[1:0]}, OFD_FMT_TABLE);
			chk("tvalid", table_access_valid, 1'b1);
			chk("taddr", table_access_addr, e);
			chk("tptr", table_pointer, p);
		end
		$display("test table finished");
		one(16'hF123, OFD_FMT_BYTE);
		chk("nop", dec_nop_reg, 1'b1);
		chk("fmt", dec_format_reg, OFD_FMT_NONE);
		two(16'hC123, 16'h2685, OFD_FMT_MOVFF);
		chk("nop", dec_nop_reg, 1'b1);
		$display("test tail words finished");
		alu(8'h88, 8'h88, 1'b0, 1'b0, 5'b11010);
		alu(8'h05, 8'h05, 1'b1, 1'b1, 5'b11100);
		$display("test flags finished");
		report_and_stop;
	end

	// watchdog well beyond the expected run length
	initial begin
		#(20 * 20000);
		n_mismatch++;
		report_and_stop;
	end
endmodule
